// [src/pol_pkg.sv]
package pol_pkg;
    // ==========================================================
    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int SYNC_PERIOD_NS = 2000; // 500 kHz switching reference
    localparam int SYNC_DIV = (SYNC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PERIOD_W = 16;
    localparam int DUTY_W = 6;  // duty in steps of 1/64
    localparam int PHASE_W = 4; // 16 steps of 22.5 degrees
    localparam int FREQ_SHIFT = 2; // free-run period is freq setting times 4 cycles
    // ==========================================================
    // device register map
    localparam logic [7:0] REG_DUTY = 8'h09;
    localparam logic [7:0] REG_PHASE = 8'h0A;
    localparam logic [7:0] REG_CFG = 8'h0B;
    localparam logic [7:0] REG_SEV = 8'h0C;
    localparam logic [7:0] REG_STAT = 8'h0D;
    localparam logic [7:0] REG_FREQ = 8'h0E;
    localparam int DUTY_LSB = 2;
    localparam logic [5:0] DUTY_RST = 6'h3A;
    localparam logic [3:0] PHASE_RST = 4'h0;
    localparam logic [7:0] CFG_RST = 8'h00;
    localparam logic [2:0] SEV_RST = 3'h0;
    localparam logic [7:0] FREQ_RST = 8'h00; // zero: lock to the sync line
    // config bits
    localparam int CFG_TRACK_DIS = 0;
    localparam int CFG_PROP_TRACK = 1;
    localparam int CFG_PROP_THERM = 2;
    localparam int CFG_PROP_CURR = 3;
    localparam int CFG_PROP_LOW = 4;
    localparam int CFG_PROP_HIGH = 5;
    // severity choice bits
    localparam int SEVC_THERM_CRIT = 0;
    localparam int SEVC_LOW_CRIT = 1;
    localparam int SEVC_HIGH_EMERG = 2;
    // status bits, one means active
    localparam int STAT_SHUT = 0;
    localparam int STAT_HIGH = 1;
    localparam int STAT_LOW = 2;
    localparam int STAT_CURR = 3;
    localparam int STAT_THERM = 4;
    localparam int STAT_TRACK = 5;
    localparam int STAT_GOOD = 6;
    localparam int STAT_TEMPW = 7;
    // ==========================================================
    // severity codes, as sent on the fault line
    localparam logic [1:0] SEV_NONE = 2'h0;
    localparam logic [1:0] SEV_SEQ = 2'h1;
    localparam logic [1:0] SEV_CRIT = 2'h2;
    localparam logic [1:0] SEV_EMERG = 2'h3;
    // ==========================================================
    // manager register map
    localparam logic [7:0] MREG_CTRL = 8'h00;
    localparam logic [7:0] MREG_STAT = 8'h01;
    localparam int MCTRL_ASSERT = 0;
    localparam int MCTRL_SEV_LSB = 1;
    localparam int MSTAT_GROUP = 2;
    localparam int MSTAT_LEVEL = 3;
endpackage

// [src/pol_link_if.sv]
`timescale 1ns/1ns
interface pol_link_if;
    logic syncLine;
    logic faultOeDev;
    logic faultOeMgr;
    logic faultLevel;
    // open-drain fault line: low while any party pulls
    assign faultLevel = ~(faultOeDev | faultOeMgr);
    modport device(input syncLine, input faultLevel, output faultOeDev);
    modport manager(output syncLine, input faultLevel, output faultOeMgr);
endinterface

// [src/load_regulator.sv]
// Operation
// - temperature warning only sets status, always on
// - good warning in steady state, reports only
// - tracking fault during ramp, fast, disableable
// - thermal fault regular off, sequenced or critical
// - current fault above prebias, fast critical
// - low output steady state, regular off
// - high output fast off, low side on
// - fault line announces and receives turn-off kind
// - fault line changes only at sync fall
// - levels sampled at fixed sync points
// - three severities sent and recognised
// - whole group applies same severity unchanged
// - 500 kHz default, other rates accepted
// - switching locked to sync falling edge
// - frequency setting private to each device
// - cycle start delayed by phase offset when locked to sync, not in free-run
// - duty limited to n over 64
// - low two bits of duty read zero
// - loop duty demand clipped at limit
// - propagating fault pulls fault line low
// - severity encoded after high-to-low transition
`timescale 1ns/1ns
module load_regulator #(
    parameter int PERIOD_W = pol_pkg::PERIOD_W
) (
    input wire logic clk,
    input wire logic rst_b,
    pol_link_if.device link,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    input wire logic powerPresent,
    input wire logic rampUp,
    input wire logic steadyState,
    input wire logic aboveBias,
    input wire logic enableIn,
    input wire logic [pol_pkg::DUTY_W-1:0] dutyDemand,
    input wire logic tempWarnIn,
    input wire logic outputGoodIn,
    input wire logic trackFaultIn,
    input wire logic thermIn,
    input wire logic currIn,
    input wire logic lowOutIn,
    input wire logic highOutIn,
    output logic pwmHigh,
    output logic lowSideOn,
    output logic fastOff,
    output logic regularOff,
    output logic powerGood
);
    typedef enum logic [2:0] {TX_IDLE, TX_BIT1, TX_BIT0, TX_HOLD} tx_e;
    typedef enum logic [1:0] {RX_IDLE, RX_BIT1, RX_BIT0, RX_LOCK} rx_e;

    function automatic logic [1:0] sevMax(input logic [1:0] a, input logic [1:0] b);
        return (a > b) ? a : b;
    endfunction

    // ==========================================================
    // pin synchronisers
    logic [2:0] syncSh_r;
    logic [1:0] faultSh_r;
    // bit 0 is the metastable stage and feeds bit 1 only
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            syncSh_r <= 3'h7;
            faultSh_r <= 2'h3;
        end else begin
            syncSh_r <= {syncSh_r[1:0], link.syncLine};
            faultSh_r <= {faultSh_r[0], link.faultLevel};
        end
    end
    wire syncFall = syncSh_r[2] & ~syncSh_r[1];
    wire syncRise = ~syncSh_r[2] & syncSh_r[1];
    wire lineLevel = faultSh_r[1];

    // ==========================================================
    // registers
    logic [pol_pkg::DUTY_W-1:0] dutyLim_r;
    logic [pol_pkg::PHASE_W-1:0] phase_r;
    logic [7:0] cfg_r;
    logic [2:0] sevCfg_r;
    logic [7:0] freq_r;
    logic [7:1] stat_r;
    logic [7:1] stat_nxt;
    logic [1:0] offSev_r;
    logic [1:0] offSev_nxt;
    logic [7:0] rdata_r;
    wire wrDuty = wr && (addr == pol_pkg::REG_DUTY);
    wire wrPhase = wr && (addr == pol_pkg::REG_PHASE);
    wire wrCfg = wr && (addr == pol_pkg::REG_CFG);
    wire wrSev = wr && (addr == pol_pkg::REG_SEV);
    wire wrStat = wr && (addr == pol_pkg::REG_STAT);
    wire wrFreq = wr && (addr == pol_pkg::REG_FREQ);
    // freq register kept per device, never shared on the link
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            dutyLim_r <= pol_pkg::DUTY_RST;
            phase_r <= pol_pkg::PHASE_RST;
            cfg_r <= pol_pkg::CFG_RST;
            sevCfg_r <= pol_pkg::SEV_RST;
            freq_r <= pol_pkg::FREQ_RST;
        end else begin
            if (wrDuty) dutyLim_r <= wdata[7:pol_pkg::DUTY_LSB];
            if (wrPhase) phase_r <= wdata[pol_pkg::PHASE_W-1:0];
            if (wrCfg) cfg_r <= wdata;
            if (wrSev) sevCfg_r <= wdata[2:0];
            if (wrFreq) freq_r <= wdata;
        end
    end

    // read mux, unmapped reads zero
    wire [7:0] rdMux =
        (addr == pol_pkg::REG_DUTY) ? {dutyLim_r, 2'b00} :
        (addr == pol_pkg::REG_PHASE) ? {4'h0, phase_r} :
        (addr == pol_pkg::REG_CFG) ? cfg_r :
        (addr == pol_pkg::REG_SEV) ? {5'h00, sevCfg_r} :
        (addr == pol_pkg::REG_STAT) ? {stat_r, offSev_r != pol_pkg::SEV_NONE} :
        (addr == pol_pkg::REG_FREQ) ? freq_r : 8'h00;
    always_ff @(posedge clk) begin
        if (!rst_b) rdata_r <= 8'h00;
        else rdata_r <= rd ? rdMux : 8'h00;
    end
    assign rdata = rdata_r;

    // ==========================================================
    // fault qualification
    wire twHit = powerPresent & tempWarnIn;
    wire goodHit = steadyState & ~outputGoodIn;
    wire trackHit = rampUp & trackFaultIn & ~cfg_r[pol_pkg::CFG_TRACK_DIS];
    wire thermHit = powerPresent & thermIn;
    wire currHit = aboveBias & currIn;
    wire lowHit = steadyState & lowOutIn;
    wire highHit = aboveBias & highOutIn;
    wire [1:0] thermSev = sevCfg_r[pol_pkg::SEVC_THERM_CRIT] ? pol_pkg::SEV_CRIT : pol_pkg::SEV_SEQ;
    wire [1:0] lowSev = sevCfg_r[pol_pkg::SEVC_LOW_CRIT] ? pol_pkg::SEV_CRIT : pol_pkg::SEV_SEQ;
    wire [1:0] highSev = sevCfg_r[pol_pkg::SEVC_HIGH_EMERG] ? pol_pkg::SEV_EMERG : pol_pkg::SEV_CRIT;
    // warnings never reach the severity, only the status
    wire [1:0] localSev = sevMax(sevMax(highHit ? highSev : pol_pkg::SEV_NONE,
                                        (trackHit | currHit) ? pol_pkg::SEV_CRIT : pol_pkg::SEV_NONE),
                                 sevMax(thermHit ? thermSev : pol_pkg::SEV_NONE,
                                        lowHit ? lowSev : pol_pkg::SEV_NONE));
    wire propagate = (trackHit & cfg_r[pol_pkg::CFG_PROP_TRACK]) | (thermHit & cfg_r[pol_pkg::CFG_PROP_THERM])
                   | (currHit & cfg_r[pol_pkg::CFG_PROP_CURR]) | (lowHit & cfg_r[pol_pkg::CFG_PROP_LOW])
                   | (highHit & cfg_r[pol_pkg::CFG_PROP_HIGH]);

    // ==========================================================
    // fault line receiver, sampled at sync rise mid-period
    rx_e rxState_r;
    logic rxBit1_r;
    wire rxDone = syncRise && (rxState_r == RX_BIT0);
    wire [1:0] rxCode = {rxBit1_r, lineLevel};
    // an all-low code is taken as critical, the safer reading
    wire [1:0] rxSev = (rxCode == pol_pkg::SEV_NONE) ? pol_pkg::SEV_CRIT : rxCode;
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rxState_r <= RX_IDLE;
            rxBit1_r <= 1'b0;
        end else if (syncRise) begin
            unique case (rxState_r)
                RX_IDLE: if (!lineLevel) rxState_r <= RX_BIT1;
                RX_BIT1: begin
                    rxBit1_r <= lineLevel;
                    rxState_r <= RX_BIT0;
                end
                RX_BIT0: rxState_r <= RX_LOCK;
                RX_LOCK: if (lineLevel) rxState_r <= RX_IDLE;
            endcase
        end
    end

    // ==========================================================
    // status and turn-off state; a new event wins over its clear
    wire [7:1] hits = {twHit, goodHit, trackHit, thermHit, currHit, lowHit, highHit};
    wire faultsLatched = |stat_r[pol_pkg::STAT_TRACK:pol_pkg::STAT_HIGH];
    always_comb begin
        stat_nxt = stat_r & ~(wrStat ? wdata[7:1] : 7'h00);
        stat_nxt = stat_nxt | hits;
        offSev_nxt = sevMax(offSev_r, sevMax(localSev, rxDone ? rxSev : pol_pkg::SEV_NONE));
        if (!faultsLatched && localSev == pol_pkg::SEV_NONE && rxState_r == RX_IDLE) begin
            offSev_nxt = pol_pkg::SEV_NONE;
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            stat_r <= 7'h00;
            offSev_r <= pol_pkg::SEV_NONE;
        end else begin
            stat_r <= stat_nxt;
            offSev_r <= offSev_nxt;
        end
    end

    // ==========================================================
    // fault line transmitter, moves only on sync fall
    // hold on local state only: our own receiver stays locked while we pull the line
    wire localActive = faultsLatched | (localSev != pol_pkg::SEV_NONE);
    tx_e txState_r;
    logic [1:0] txCode_r;
    logic faultOe_r;
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            txState_r <= TX_IDLE;
            txCode_r <= pol_pkg::SEV_NONE;
            faultOe_r <= 1'b0;
        end else if (syncFall) begin
            unique case (txState_r)
                TX_IDLE: if (propagate && localSev != pol_pkg::SEV_NONE) begin
                    faultOe_r <= 1'b1;
                    txCode_r <= localSev;
                    txState_r <= TX_BIT1;
                end
                TX_BIT1: begin
                    faultOe_r <= ~txCode_r[1];
                    txState_r <= TX_BIT0;
                end
                TX_BIT0: begin
                    faultOe_r <= ~txCode_r[0];
                    txState_r <= TX_HOLD;
                end
                TX_HOLD: begin
                    faultOe_r <= localActive;
                    if (!localActive) txState_r <= TX_IDLE;
                end
                default: txState_r <= TX_IDLE;
            endcase
        end
    end
    assign link.faultOeDev = faultOe_r;

    // ==========================================================
    // pwm timing: period measured between sync falls
    logic [PERIOD_W-1:0] sinceFall_r;
    logic [PERIOD_W-1:0] period_r;
    logic [PERIOD_W-1:0] cyc_r;
    wire locked = (freq_r == pol_pkg::FREQ_RST);
    wire [PERIOD_W-1:0] freqPeriod = PERIOD_W'({freq_r, {pol_pkg::FREQ_SHIFT{1'b0}}});
    wire [PERIOD_W-1:0] periodEff = locked ? period_r : freqPeriod;
    wire [PERIOD_W+pol_pkg::PHASE_W-1:0] phaseProd = periodEff * phase_r;
    wire [PERIOD_W-1:0] phaseDelay = phaseProd[PERIOD_W+pol_pkg::PHASE_W-1:pol_pkg::PHASE_W];
    wire [pol_pkg::DUTY_W-1:0] effDuty = (dutyDemand > dutyLim_r) ? dutyLim_r : dutyDemand;
    wire [PERIOD_W+pol_pkg::DUTY_W-1:0] onProd = periodEff * effDuty;
    wire [PERIOD_W-1:0] onTime = onProd[PERIOD_W+pol_pkg::DUTY_W-1:pol_pkg::DUTY_W];
    wire cycStart = locked ? (sinceFall_r == phaseDelay) : (cyc_r >= periodEff - PERIOD_W'(1));
    wire runOk = enableIn && (offSev_r < pol_pkg::SEV_CRIT); // fast turn-off stops at once
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sinceFall_r <= '0;
            period_r <= '0;
            cyc_r <= '0;
        end else begin
            sinceFall_r <= syncFall ? '0 : sinceFall_r + PERIOD_W'(1);
            if (syncFall) period_r <= sinceFall_r + PERIOD_W'(1);
            cyc_r <= cycStart ? '0 : cyc_r + PERIOD_W'(1);
        end
    end

    // ==========================================================
    // output stage, all registered
    logic pwmHigh_r;
    logic lowSide_r;
    logic fastOff_r;
    logic regularOff_r;
    logic powerGood_r;
    wire highOn = runOk && (cyc_r < onTime);
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pwmHigh_r <= 1'b0;
            lowSide_r <= 1'b0;
            fastOff_r <= 1'b0;
            regularOff_r <= 1'b0;
            powerGood_r <= 1'b0;
        end else begin
            pwmHigh_r <= highOn;
            // emergency holds low side on to clamp the output
            lowSide_r <= (offSev_nxt == pol_pkg::SEV_EMERG) | (runOk & ~highOn);
            fastOff_r <= (offSev_nxt >= pol_pkg::SEV_CRIT);
            regularOff_r <= (offSev_nxt == pol_pkg::SEV_SEQ);
            powerGood_r <= steadyState & outputGoodIn;
        end
    end
    assign pwmHigh = pwmHigh_r;
    assign lowSideOn = lowSide_r;
    assign fastOff = fastOff_r;
    assign regularOff = regularOff_r;
    assign powerGood = powerGood_r;
endmodule // load_regulator

// [src/power_manager.sv]
`timescale 1ns/1ns
module power_manager #(
    parameter int PERIOD_W = pol_pkg::PERIOD_W,
    parameter int SYNC_DIV = pol_pkg::SYNC_DIV
) (
    input wire logic clk,
    input wire logic rst_b,
    pol_link_if.manager link,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    output logic groupFault,
    output logic [1:0] groupSev
);
    typedef enum logic [1:0] {TX_IDLE, TX_BIT1, TX_BIT0, TX_HOLD} tx_e;
    typedef enum logic [1:0] {RX_IDLE, RX_BIT1, RX_BIT0, RX_LOCK} rx_e;
    localparam logic [PERIOD_W-1:0] LAST = PERIOD_W'(SYNC_DIV - 1);
    localparam logic [PERIOD_W-1:0] HALF = PERIOD_W'(SYNC_DIV / 2 - 1);

    // ==========================================================
    // sync divider: low half then high half
    logic [PERIOD_W-1:0] cnt_r;
    logic sync_r;
    wire fallNow = (cnt_r == LAST);
    wire riseNow = (cnt_r == HALF);
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cnt_r <= '0;
            sync_r <= 1'b1;
        end else begin
            cnt_r <= fallNow ? '0 : cnt_r + PERIOD_W'(1);
            if (fallNow) sync_r <= 1'b0;
            else if (riseNow) sync_r <= 1'b1;
        end
    end
    assign link.syncLine = sync_r;

    // ==========================================================
    // fault line synchroniser, stage 0 feeds stage 1 only
    logic [1:0] faultSh_r;
    always_ff @(posedge clk) begin
        if (!rst_b) faultSh_r <= 2'h3;
        else faultSh_r <= {faultSh_r[0], link.faultLevel};
    end
    wire lineLevel = faultSh_r[1];

    // ==========================================================
    // control register and forward request
    logic assert_r;
    logic [1:0] fwdSev_r;
    wire wrCtrl = wr && (addr == pol_pkg::MREG_CTRL);
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            assert_r <= 1'b0;
            fwdSev_r <= pol_pkg::SEV_NONE;
        end else if (wrCtrl) begin
            assert_r <= wdata[pol_pkg::MCTRL_ASSERT];
            fwdSev_r <= wdata[pol_pkg::MCTRL_SEV_LSB +: 2];
        end
    end

    // ==========================================================
    // receiver, samples at sync rise
    rx_e rxState_r;
    logic rxBit1_r;
    logic [1:0] groupSev_r;
    logic groupFault_r;
    wire [1:0] rxCode = {rxBit1_r, lineLevel};
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rxState_r <= RX_IDLE;
            rxBit1_r <= 1'b0;
            groupSev_r <= pol_pkg::SEV_NONE;
            groupFault_r <= 1'b0;
        end else if (riseNow) begin
            unique case (rxState_r)
                RX_IDLE: if (!lineLevel) rxState_r <= RX_BIT1;
                RX_BIT1: begin
                    rxBit1_r <= lineLevel;
                    rxState_r <= RX_BIT0;
                end
                RX_BIT0: begin
                    groupSev_r <= (rxCode == pol_pkg::SEV_NONE) ? pol_pkg::SEV_CRIT : rxCode;
                    groupFault_r <= 1'b1;
                    rxState_r <= RX_LOCK;
                end
                RX_LOCK: if (lineLevel) begin
                    groupFault_r <= 1'b0;
                    rxState_r <= RX_IDLE;
                end
            endcase
        end
    end
    assign groupFault = groupFault_r;
    assign groupSev = groupSev_r;

    // ==========================================================
    // forwarding transmitter, same framing as the devices
    tx_e txState_r;
    logic [1:0] txCode_r;
    logic faultOe_r;
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            txState_r <= TX_IDLE;
            txCode_r <= pol_pkg::SEV_NONE;
            faultOe_r <= 1'b0;
        end else if (fallNow) begin
            unique case (txState_r)
                TX_IDLE: if (assert_r && fwdSev_r != pol_pkg::SEV_NONE) begin
                    faultOe_r <= 1'b1;
                    txCode_r <= fwdSev_r;
                    txState_r <= TX_BIT1;
                end
                TX_BIT1: begin
                    faultOe_r <= ~txCode_r[1];
                    txState_r <= TX_BIT0;
                end
                TX_BIT0: begin
                    faultOe_r <= ~txCode_r[0];
                    txState_r <= TX_HOLD;
                end
                TX_HOLD: begin
                    faultOe_r <= assert_r;
                    if (!assert_r) txState_r <= TX_IDLE;
                end
            endcase
        end
    end
    assign link.faultOeMgr = faultOe_r;

    // ==========================================================
    // read port, unmapped reads zero
    logic [7:0] rdata_r;
    wire [7:0] statWord = {4'h0, lineLevel, groupFault_r, groupSev_r};
    wire [7:0] ctrlWord = {5'h00, fwdSev_r, assert_r};
    wire [7:0] rdMux = (addr == pol_pkg::MREG_CTRL) ? ctrlWord :
                       (addr == pol_pkg::MREG_STAT) ? statWord : 8'h00;
    always_ff @(posedge clk) begin
        if (!rst_b) rdata_r <= 8'h00;
        else rdata_r <= rd ? rdMux : 8'h00;
    end
    assign rdata = rdata_r;
endmodule // power_manager

// [verification/pol_link_asserts.sv]
`timescale 1ns/1ns
// ==========================================
// link timing checks
module pol_link_asserts (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic syncLine,
    input wire logic faultOeDev,
    input wire logic faultOeMgr,
    input wire logic faultLevel
);
    logic syncPrev_r;
    logic armed_r;
    logic [3:0] sinceFall_r;
    // age of the last sync fall; saturates so a stopped line never wraps
    always_ff @(posedge clk) begin
        syncPrev_r <= syncLine;
        armed_r <= rst_b & (armed_r | (~syncPrev_r & syncLine)); // the sync half checks skip everything up to the first sync rise after reset
        if (syncPrev_r & ~syncLine)
            sinceFall_r <= 4'h0;
        else if (sinceFall_r != 4'hF)
            sinceFall_r <= sinceFall_r + 4'h1;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    property p_dev_at_fall; $changed(faultOeDev) |-> sinceFall_r <= 4'h5; endproperty
    a_dev_at_fall: assert property (p_dev_at_fall) else $error("device fault drive moved off a sync fall");
    property p_mgr_at_fall; $changed(faultOeMgr) |-> $fell(syncLine) || sinceFall_r <= 4'h1; endproperty
    a_mgr_at_fall: assert property (p_mgr_at_fall) else $error("manager fault drive moved off a sync fall");
    property p_line_at_fall; $changed(faultLevel) |-> $fell(syncLine) || sinceFall_r <= 4'h5; endproperty
    a_line_at_fall: assert property (p_line_at_fall) else $error("fault line moved off a sync fall");
    property p_sync_low; armed_r && $fell(syncLine) |-> !syncLine [*8] ##1 syncLine; endproperty
    a_sync_low: assert property (p_sync_low) else $error("sync low half not eight cycles");
    property p_sync_high; armed_r && $rose(syncLine) |-> syncLine [*8] ##1 !syncLine; endproperty
    a_sync_high: assert property (p_sync_high) else $error("sync high half not eight cycles");
    property p_start_low; $rose(faultOeDev) |-> !syncLine; endproperty
    a_start_low: assert property (p_start_low) else $error("device pulled the line outside a low sync half");
    property p_pull_hold; $rose(faultOeDev) |-> faultOeDev [*8] ##1 faultOeDev [*8]; endproperty
    a_pull_hold: assert property (p_pull_hold) else $error("device pull shorter than one sync period");
    property p_rel_hold; $fell(faultOeDev) |-> !faultOeDev [*8] ##1 !faultOeDev [*8]; endproperty
    a_rel_hold: assert property (p_rel_hold) else $error("device release shorter than one sync period");
endmodule // pol_link_asserts

// [verification/test_pol_fault_and_pwm_timing.sv]
`timescale 1ns/1ns
// ==========================================
// regulator and manager joined on one link
module test_pol_fault_and_pwm_timing;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wrD = 1'b0, rdD = 1'b0, wrM = 1'b0, rdM = 1'b0;
    logic [7:0] rdataD, rdataM;
    logic [3:0] phase = 4'hB; // power, ramp, steady, above bias
    logic [5:0] hit = 6'h00; // temp warn, track, thermal, current, low, high
    logic [5:0] demand = 6'h00;
    logic enableIn = 1'b1;
    logic goodIn = 1'b1;
    logic pwmHigh, lowSideOn, fastOff, regularOff, groupFault, powerGood;
    logic [1:0] groupSev;
    int mismatches = 0;
    int checked = 0;
    int n;
    // 100 MHz; the sync line runs at 160 ns through SYNC_DIV
    always #5 clk = ~clk;
    pol_link_if lnk();
    load_regulator load_regulator_inst(.clk(clk), .rst_b(rst_b), .link(lnk), .addr(addr), .wdata(wdata),
        .wr(wrD), .rd(rdD), .rdata(rdataD), .powerPresent(phase[3]), .rampUp(phase[2]), .steadyState(phase[1]),
        .aboveBias(phase[0]), .enableIn(enableIn), .dutyDemand(demand), .tempWarnIn(hit[5]),
        .outputGoodIn(goodIn), .trackFaultIn(hit[4]), .thermIn(hit[3]), .currIn(hit[2]), .lowOutIn(hit[1]),
        .highOutIn(hit[0]), .pwmHigh(pwmHigh), .lowSideOn(lowSideOn), .fastOff(fastOff),
        .regularOff(regularOff), .powerGood(powerGood));
    power_manager #(.SYNC_DIV(16)) power_manager_inst(.clk(clk), .rst_b(rst_b), .link(lnk), .addr(addr),
        .wdata(wdata), .wr(wrM), .rd(rdM), .rdata(rdataM), .groupFault(groupFault), .groupSev(groupSev));
    pol_link_asserts pol_link_asserts_inst(.clk(clk), .rst_b(rst_b), .syncLine(lnk.syncLine),
        .faultOeDev(lnk.faultOeDev), .faultOeMgr(lnk.faultOeMgr), .faultLevel(lnk.faultLevel));
    // ==========================================
    // access and compare tasks
    task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic m, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wrM <= m;
        wrD <= ~m;
        @(posedge clk);
        wrM <= 1'b0;
        wrD <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input string nm, input logic m, input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rdM <= m;
        rdD <= ~m;
        @(posedge clk);
        rdM <= 1'b0;
        rdD <= 1'b0;
        @(posedge clk);
        chk(nm, m ? rdataM : rdataD, exp);
    endtask
    // four sync periods hold exactly four on-times of high cycles whatever the phase
    task automatic pwm(input logic [5:0] lim, input logic [5:0] d);
        wr(1'b0, pol_pkg::REG_DUTY, {lim, 2'b00});
        demand <= d;
        repeat (48) @(posedge clk);
        n = 0;
        repeat (64) @(posedge clk) n += pwmHigh;
        chk("pwm", 8'(n), 8'(4 * ((16 * (lim < d ? lim : d)) / 64)));
    endtask
    task automatic end_sim();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // ==========================================
    // main sequence
    initial begin
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        rd("ceil", 1'b0, pol_pkg::REG_DUTY, 8'hE8);
        wr(1'b0, pol_pkg::REG_DUTY, 8'hFF);
        rd("ceil", 1'b0, pol_pkg::REG_DUTY, 8'hFC);
        rd("unmap", 1'b0, 8'h30, 8'h00);
        wr(1'b0, pol_pkg::REG_PHASE, 8'h04);
        rd("phase", 1'b0, pol_pkg::REG_PHASE, 8'h04);
        pwm(6'd32, 6'd63);
        pwm(6'd63, 6'd63);
        pwm(6'd0, 6'd63);
        pwm(6'd63, 6'd16);
        wr(1'b0, pol_pkg::REG_FREQ, 8'h04);
        pwm(6'd63, 6'd40);
        // a warning only latches status
        hit <= 6'h20;
        goodIn <= 1'b0;
        repeat (100) @(posedge clk);
        rd("stat", 1'b0, pol_pkg::REG_STAT, 8'hC0);
        chk("warn", {fastOff, regularOff, lnk.faultOeDev, powerGood}, 8'h00);
        hit <= 6'h00;
        goodIn <= 1'b1;
        wr(1'b0, pol_pkg::REG_STAT, 8'hFF);
        // device sends each severity, manager decodes it
        wr(1'b0, pol_pkg::REG_CFG, 8'h24);
        for (int k = 0; k < 3; k++) begin
            wr(1'b0, pol_pkg::REG_SEV, k == 0 ? 8'h00 : k == 1 ? 8'h01 : 8'h04);
            hit <= k == 2 ? 6'h01 : 6'h08;
            repeat (200) @(posedge clk);
            rd("mstat", 1'b1, pol_pkg::MREG_STAT, 8'h04 | 8'(k + 1));
            chk("gsev", groupSev, 8'(k + 1));
            chk("offs", {fastOff, regularOff, k == 0 ? 1'b0 : lowSideOn}, {k != 0, k == 0, k == 2});
            hit <= 6'h00;
            wr(1'b0, pol_pkg::REG_STAT, 8'hFF);
            repeat (200) @(posedge clk);
            chk("release", {groupFault, lnk.faultLevel}, 8'h01);
        end
        // manager forwards each severity, device obeys it
        for (int c = 1; c < 4; c++) begin
            wr(1'b1, pol_pkg::MREG_CTRL, 8'(c * 2 + 1));
            repeat (200) @(posedge clk);
            chk("recv", {fastOff, regularOff}, {c > 1, c == 1});
            wr(1'b1, pol_pkg::MREG_CTRL, 8'h00);
            repeat (200) @(posedge clk);
            chk("recvoff", {fastOff, regularOff}, 8'h00);
        end
        // tracking check during ramp, disabled then enabled
        phase <= 4'hD;
        wr(1'b0, pol_pkg::REG_CFG, 8'h01);
        hit <= 6'h10;
        repeat (100) @(posedge clk);
        chk("trkoff", fastOff, 8'h00);
        wr(1'b0, pol_pkg::REG_CFG, 8'h00);
        repeat (100) @(posedge clk);
        chk("trkon", fastOff, 8'h01);
        end_sim();
    end
    // cut a hang short well past the expected run time
    initial begin
        #200000;
        mismatches++;
        end_sim();
    end
endmodule // test_pol_fault_and_pwm_timing
